// File: hw/srw_pkg.sv
// constants and types for the reset supervisor with watchdog
package srw_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned STRETCH_MS = 250;
    localparam int unsigned DEBOUNCE_MS = 20;
    localparam int unsigned WD_SHORT_MS = 150;
    localparam int unsigned WD_MID_MS = 600;
    localparam int unsigned WD_LONG_MS = 1200;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned STRETCH_CYC = STRETCH_MS * CYC_PER_MS;
    localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
    localparam int unsigned WD_SHORT_CYC = WD_SHORT_MS * CYC_PER_MS;
    localparam int unsigned WD_MID_CYC = WD_MID_MS * CYC_PER_MS;
    localparam int unsigned WD_LONG_CYC = WD_LONG_MS * CYC_PER_MS;
    localparam int CNT_W = 32;
    // timeout_select strap encodings
    localparam logic [1:0] TSEL_LOW = 2'h0;
    localparam logic [1:0] TSEL_FLOAT = 2'h1;
    localparam logic [1:0] TSEL_HIGH = 2'h2;
    typedef enum logic [2:0] {
        SRW_HOLD = 3'h1,
        SRW_RUN = 3'h2,
        SRW_TRIP = 3'h4
    } srw_state_e;
endpackage

// File: hw/srw_debounce.sv
// pushbutton debouncer: level accepted only after stable for a count
`timescale 1ns/1ps
module srw_debounce #(
    parameter int unsigned STABLE_CYC = 2
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // raw and filtered button
    input wire logic btn_n_i,
    output logic press_o
);
    logic [31:0] cnt_reg;
    logic press_reg;
    assign press_o = press_reg;

    // counter restarts whenever raw level agrees with accepted level
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cnt_reg <= 32'h0;
        end else if ((!btn_n_i) == press_reg) begin
            cnt_reg <= 32'h0;
        end else if (cnt_reg >= STABLE_CYC - 1) begin
            cnt_reg <= 32'h0;
        end else begin
            cnt_reg <= cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            press_reg <= 1'b0;
        end else if (((!btn_n_i) != press_reg) && (cnt_reg >= STABLE_CYC - 1)) begin
            press_reg <= !btn_n_i;
        end
    end

    short_low_ignored_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (!press_reg && btn_n_i) |=> !press_reg) else $error("press accepted while button high");
endmodule

// File: hw/srw_supervisor.sv
// reset supervisor: supply fail, debounced pushbutton and watchdog
// Summary of operation
// - supply fail forces both resets active
// - hold reset 250 ms after supply recovers
// - tolerance strap passed to comparator select
// - active-low reset is open drain only
// - pushbutton input is debounced internally
// - reset held 250 ms after debounced button release
// - missed kick within timeout asserts reset
// - timeout strap picks 150/600/1200 ms period
// - watchdog counts only while reset inactive
// - kick falling edge restarts full period
// - expiry gives 250 ms reset then restart
// - watchdog cannot be disabled
`timescale 1ns/1ps
module srw_supervisor #(
    parameter int unsigned STRETCH_CYC = srw_pkg::STRETCH_CYC,
    parameter int unsigned DEBOUNCE_CYC = srw_pkg::DEBOUNCE_CYC,
    parameter int unsigned WD_SHORT_CYC = srw_pkg::WD_SHORT_CYC,
    parameter int unsigned WD_MID_CYC = srw_pkg::WD_MID_CYC,
    parameter int unsigned WD_LONG_CYC = srw_pkg::WD_LONG_CYC
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // supply monitor
    input wire logic supply_fail_i,
    input wire logic tolerance_select_i,
    output logic trip_low_sel_o,
    // straps and processor inputs
    input wire logic [1:0] timeout_select_i,
    input wire logic pushbutton_reset_n_i,
    input wire logic watchdog_kick_i,
    // reset outputs
    output logic reset_o,
    output logic reset_n_o,
    output logic reset_n_oe_o
);
    srw_pkg::srw_state_e state_reg;
    logic [31:0] stretch_reg;
    logic [31:0] wd_reg;
    logic [31:0] wd_period;
    logic kick_reg;
    logic rst_reg;
    logic press;
    logic kick_fall;
    logic cause;
    logic wd_expire;
    // helper counts read only by the timing assertions
    logic [31:0] hold_cnt_reg;
    logic [31:0] low_run_reg;

    // tolerance strap only steers the analog trip level
    assign trip_low_sel_o = tolerance_select_i;

    srw_debounce #(
        .STABLE_CYC(DEBOUNCE_CYC)
    ) u_debounce (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .btn_n_i(pushbutton_reset_n_i),
        .press_o(press)
    );

    always_comb begin
        case (timeout_select_i)
            srw_pkg::TSEL_LOW: wd_period = WD_SHORT_CYC;
            srw_pkg::TSEL_FLOAT: wd_period = WD_MID_CYC;
            srw_pkg::TSEL_HIGH: wd_period = WD_LONG_CYC;
            default: wd_period = WD_LONG_CYC;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            kick_reg <= 1'b1;
        end else begin
            kick_reg <= watchdog_kick_i;
        end
    end
    assign kick_fall = kick_reg && !watchdog_kick_i;

    assign wd_expire = (state_reg == srw_pkg::SRW_RUN) && (wd_reg == 32'h0);
    // any live cause retriggers the single stretch counter
    assign cause = supply_fail_i || press || wd_expire;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            stretch_reg <= STRETCH_CYC;
        end else if (cause) begin
            stretch_reg <= STRETCH_CYC;
        end else if (stretch_reg != 32'h0) begin
            stretch_reg <= stretch_reg - 32'h1;
        end
    end

    // power-up behaves as a supply recovery: reset starts active
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state_reg <= srw_pkg::SRW_HOLD;
        end else begin
            case (state_reg)
                srw_pkg::SRW_HOLD: begin
                    if (!cause && stretch_reg == 32'h0) begin
                        state_reg <= srw_pkg::SRW_RUN;
                    end
                end
                srw_pkg::SRW_RUN: begin
                    if (wd_expire) begin
                        state_reg <= srw_pkg::SRW_TRIP;
                    end else if (cause) begin
                        state_reg <= srw_pkg::SRW_HOLD;
                    end
                end
                srw_pkg::SRW_TRIP: state_reg <= srw_pkg::SRW_HOLD;
                default: state_reg <= srw_pkg::SRW_HOLD;
            endcase
        end
    end

    // no enable input exists: the count always runs outside reset
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wd_reg <= 32'h0;
        // reset_o lags the state by one edge: hold the count until it has fallen
        end else if (state_reg != srw_pkg::SRW_RUN || rst_reg) begin
            wd_reg <= wd_period - 32'h1;
        end else if (kick_fall) begin
            wd_reg <= wd_period - 32'h1;
        end else if (wd_reg != 32'h0) begin
            wd_reg <= wd_reg - 32'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rst_reg <= 1'b1;
        end else begin
            rst_reg <= (state_reg != srw_pkg::SRW_RUN) || cause;
        end
    end

    assign reset_o = rst_reg;
    assign reset_n_o = 1'b0;
    assign reset_n_oe_o = rst_reg;

    // cycles reset has stood since the last live cause
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || cause) begin
            hold_cnt_reg <= 32'h0;
        end else if (rst_reg && hold_cnt_reg != 32'hFFFF_FFFF) begin
            hold_cnt_reg <= hold_cnt_reg + 32'h1;
        end
    end

    // consecutive low samples of the raw button
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || pushbutton_reset_n_i) begin
            low_run_reg <= 32'h0;
        end else if (low_run_reg != 32'hFFFF_FFFF) begin
            low_run_reg <= low_run_reg + 32'h1;
        end
    end

    // immediate effects of each cause
    supply_forces_reset_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        supply_fail_i |=> reset_o) else $error("supply fail without reset");
    stretch_reload_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        cause |=> stretch_reg == STRETCH_CYC) else $error("stretch not reloaded");
    tolerance_pass_a: assert property (@(posedge mclk_i)
        trip_low_sel_o == tolerance_select_i) else $error("tolerance select lost");
    open_drain_a: assert property (@(posedge mclk_i)
        (reset_n_oe_o == reset_o) && !reset_n_o) else $error("active-low reset not open drain");
    press_resets_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        press |=> reset_o) else $error("press without reset");
    press_debounced_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $rose(press) |-> low_run_reg >= DEBOUNCE_CYC) else $error("press accepted before debounce");

    // release only after the full stretch has run out
    reset_held_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (stretch_reg != 32'h0) |=> reset_o) else $error("reset released early");
    sequence released_s;
        !reset_o && state_reg == srw_pkg::SRW_RUN && stretch_reg == 32'h0;
    endsequence
    reset_release_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $fell(reset_o) |-> released_s) else $error("reset left without stretch");
    hold_window_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $fell(reset_o) |-> hold_cnt_reg >= STRETCH_CYC && hold_cnt_reg <= STRETCH_CYC + 32'h4)
        else $error("reset stretch out of window");

    // watchdog: frozen in reset, counts down otherwise, restarts on a fall
    wd_frozen_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (state_reg != srw_pkg::SRW_RUN) |=> wd_reg == $past(wd_period) - 32'h1)
        else $error("watchdog ran in reset");
    wd_idle_reset_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        reset_o |=> wd_reg == $past(wd_period) - 32'h1) else $error("watchdog ran while reset stood");
    wd_counts_down_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (state_reg == srw_pkg::SRW_RUN && !reset_o && !kick_fall && wd_reg != 32'h0)
        |=> wd_reg == $past(wd_reg) - 32'h1) else $error("watchdog stalled");
    kick_restart_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (kick_fall && state_reg == srw_pkg::SRW_RUN) |=> wd_reg == $past(wd_period) - 32'h1)
        else $error("kick did not restart");

    // expiry: trip state, then hold with the stretch running
    expiry_trip_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        wd_expire |=> state_reg == srw_pkg::SRW_TRIP ##1 reset_o) else $error("expiry missed");
    sequence trip_step_s;
        state_reg == srw_pkg::SRW_TRIP && reset_o;
    endsequence
    sequence hold_step_s;
        state_reg == srw_pkg::SRW_HOLD && reset_o && stretch_reg != 32'h0;
    endsequence
    expiry_steps_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        wd_expire |=> trip_step_s ##1 hold_step_s) else $error("expiry steps out of order");
endmodule

// File: bench/srw_cpu_model.sv
// processor model: kicks the watchdog with short low pulses
`timescale 1ns/1ps
module srw_cpu_model #(
    parameter int unsigned KICK_CYC = 30
) (
    // clock and observed reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // kick control and strobe
    input wire logic kick_en_i,
    output logic kick_o
);
    int unsigned cnt = 0;
    initial kick_o = 1'b1;
    // one-cycle low pulse keeps low time far below any timeout
    always @(posedge mclk_i) begin
        #1;
        if (reset_i || !kick_en_i) begin
            cnt = 0;
            kick_o = 1'b1;
        end else if (cnt == KICK_CYC - 1) begin
            cnt = 0;
            kick_o = 1'b0;
        end else begin
            cnt++;
            kick_o = 1'b1;
        end
    end
endmodule

// File: bench/srw_supervisor_bench.sv
// bench for the reset supervisor with watchdog
`timescale 1ns/1ps
module srw_supervisor_bench;
    localparam int ST = 20;
    localparam int DB = 4;
    logic mclk_i = 0, sys_rst_i = 1, supply_fail = 0, tolerance_select = 0, btn_n = 1, kick_en = 0;
    logic [1:0] tsel = 2'h0;
    logic trip, rst, rst_n, rst_oe, kick, pin;
    int failures = 0, n_compared = 0, n;
    // rows: timeout_select value -> expected period
    int wd[4] = '{50, 100, 200, 200};
    assign pin = rst_oe ? rst_n : 1'b1; // pull-up when released
    initial forever #5 mclk_i = ~mclk_i;
    srw_supervisor #(.STRETCH_CYC(ST), .DEBOUNCE_CYC(DB), .WD_SHORT_CYC(50), .WD_MID_CYC(100),
        .WD_LONG_CYC(200)) dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .supply_fail_i(supply_fail),
        .tolerance_select_i(tolerance_select), .trip_low_sel_o(trip), .timeout_select_i(tsel),
        .pushbutton_reset_n_i(btn_n), .watchdog_kick_i(kick), .reset_o(rst), .reset_n_o(rst_n),
        .reset_n_oe_o(rst_oe));
    srw_cpu_model #(.KICK_CYC(30)) cpu (.mclk_i(mclk_i), .reset_i(rst), .kick_en_i(kick_en), .kick_o(kick));
    task chk(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_rng(input int got, input int lo, input int hi);
        n_compared++;
        if (got < lo || got > hi) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask
    // bounded wait so a stuck reset cannot hang the run
    task wait_rst(input logic lvl, output int k);
        k = 0;
        while (rst !== lvl && k < 5000) begin
            cyc(1);
            k++;
        end
    endtask
    task wrap_up;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        wrap_up();
    end
    initial begin
        cyc(8);
        sys_rst_i = 0;
        chk(rst, 1'b1);
        chk(pin, 1'b0);
        wait_rst(1'b0, n);
        chk_rng(n, ST, ST + 4);
        chk(pin, 1'b1);
        $display("test power-up done");
        for (int i = 0; i < 4; i++) begin
            tsel = i[1:0];
            tolerance_select = i[0];
            supply_fail = 1;
            cyc(1);
            chk(trip, tolerance_select);
            chk(rst, 1'b1);
            supply_fail = 0;
            wait_rst(1'b0, n);
            chk_rng(n, ST, ST + 4);
            wait_rst(1'b1, n);
            chk_rng(n, wd[i] - 1, wd[i] + 2);
            wait_rst(1'b0, n);
            chk_rng(n, ST, ST + 4);
            $display("test timeout row %0d done", i);
        end
        tsel = 2'h0;
        kick_en = 1;
        btn_n = 0;
        cyc(DB - 2);
        btn_n = 1;
        cyc(3);
        chk(rst, 1'b0);
        btn_n = 0;
        cyc(DB + 3);
        chk(rst, 1'b1);
        cyc(10);
        btn_n = 1;
        wait_rst(1'b0, n);
        chk_rng(n, ST, ST + DB + 4);
        $display("test pushbutton done");
        cyc(300);
        chk(rst, 1'b0);
        kick_en = 0;
        wait_rst(1'b1, n);
        chk_rng(n, 19, 52);
        $display("test kick done");
        sys_rst_i = 1;
        cyc(2);
        chk(rst, 1'b1);
        sys_rst_i = 0;
        chk(pin, 1'b0);
        wait_rst(1'b0, n);
        chk_rng(n, ST, ST + 4);
        chk(pin, 1'b1);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule
